// *** core/tmr16_pkg.sv ***
package tmr16_pkg;
   localparam logic [7:0]  OFS_MODE       = 8'h00;
   localparam logic [7:0]  OFS_CAP_CTRL   = 8'h04;
   localparam logic [7:0]  OFS_OUT_CTRL   = 8'h08;
   localparam logic [7:0]  OFS_PRESCALE   = 8'h0C;
   localparam logic [7:0]  OFS_COUNTER    = 8'h10;
   localparam logic [7:0]  OFS_CC_A       = 8'h14;
   localparam logic [7:0]  OFS_CC_B       = 8'h18;
   localparam logic [7:0]  OFS_STATUS     = 8'h1C;

   localparam int          POS_OVF        = 0;
   localparam int          POS_RUN        = 2;
   localparam int          POS_CAPA_EN    = 0;
   localparam int          POS_CAPA_SRC   = 1;
   localparam int          POS_CAPB_EN    = 2;
   localparam int          POS_OUT_EN     = 0;
   localparam int          POS_OS_EN      = 4;
   localparam int          POS_SOFT_TRIG  = 6;
   localparam int          POS_CLK_SEL    = 0;
   localparam int          POS_ES_TRIG    = 4;
   localparam int          POS_ES_CAP2    = 6;

   localparam logic [15:0] CNT_MAX        = 16'hFFFF;
   localparam logic [15:0] CNT_ONE        = 16'h0001;
   localparam logic [1:0]  RESP_OKAY      = 2'h0;
   localparam logic [1:0]  RESP_SLVERR    = 2'h2;
   localparam logic [3:0]  DIV_MASK_A     = 4'h3;
   localparam logic [3:0]  DIV_MASK_B     = 4'hF;

   typedef enum logic [1:0] {
      RUN_STOP, RUN_EDGE_CLR, RUN_FREE, RUN_MATCH_CLR
   } run_mode_e;

   typedef enum logic [1:0] {
      CLK_MAIN, CLK_DIV_A, CLK_DIV_B, CLK_TRIG_EDGE
   } clk_sel_e;

   typedef enum logic [1:0] {
      EDGE_FALL, EDGE_RISE, EDGE_NONE, EDGE_BOTH
   } edge_sel_e;

   typedef struct packed {
      run_mode_e run_mode;
      clk_sel_e  clk_sel;
      edge_sel_e es_trig;
      edge_sel_e es_cap2;
      logic      capa_en;
      logic      capa_src;
      logic      capb_en;
      logic      out_en;
      logic      os_en;
   } ctrl_s;

   localparam ctrl_s CTRL_RST = '{RUN_STOP, CLK_MAIN, EDGE_FALL,
                                  EDGE_FALL, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0};
endpackage

// *** core/timer16_one_shot_capture.sv ***
`timescale 1ns/1ps
module timer16_one_shot_capture (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        trigger_input,
   input  wire logic        second_capture_input,
   output logic             pulse_output,
   output logic             match_a_irq,
   output logic             match_b_irq
);
   import tmr16_pkg::*;

   tmr16_pkg::ctrl_s ctrl;
   logic [15:0] up_counter;
   logic [15:0] capture_compare_a;
   logic [15:0] capture_compare_b;
   logic        overflow_flag;
   logic        ovf_hold;
   logic [7:0]  aw_addr;
   logic        aw_got;
   logic        w_got;
   logic [31:0] w_data;
   logic [3:0]  w_strb;
   logic        wr_go;
   logic [3:0]  div;
   logic        pre_tick;
   logic        tick;
   logic        running;
   logic        first_run;
   logic        start_ev;
   logic        busy;
   logic        pulse_q;
   logic [1:0]  pin;
   logic [1:0]  samp_en;
   logic [1:0]  filt;
   logic [1:0]  sh0;
   logic [1:0]  sh1;
   logic [1:0]  rise;
   logic [1:0]  fall;
   logic        trig_valid;
   logic        cap2_valid;
   logic        os_mode_ok;
   logic        soft_go;
   logic        ext_go;
   logic        os_go;
   logic        clear_ev;
   logic [15:0] lo_val;
   logic [15:0] hi_val;
   logic        start_hit;
   logic        end_hit;
   logic        match_a_ev;
   logic        match_b_ev;
   logic        cap_a_ev;
   logic        cap_b_ev;
   logic        wrap_ev;
   logic [31:0] rd_val;
   logic        rd_ok;

   function automatic logic [15:0] merge16(input logic [15:0] old,
                                           input logic [31:0] d,
                                           input logic [3:0]  s);
      merge16 = {s[1] ? d[15:8] : old[15:8], s[0] ? d[7:0] : old[7:0]};
   endfunction

   function automatic logic sel_edge(input edge_sel_e es,
                                     input logic r,
                                     input logic f);
      case (es)
         EDGE_FALL: sel_edge = f;
         EDGE_RISE: sel_edge = r;
         EDGE_BOTH: sel_edge = r | f;
         default:   sel_edge = 1'b0;
      endcase
   endfunction

   // Write channel: address and data taken in either order
   assign wr_go = aw_got & w_got & ~s_axi_bvalid;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         s_axi_wready  <= 1'b0;
         s_axi_bvalid  <= 1'b0;
         s_axi_bresp   <= RESP_OKAY;
         aw_got        <= 1'b0;
         w_got         <= 1'b0;
         aw_addr       <= 8'h00;
         w_data        <= 32'h0000_0000;
         w_strb        <= 4'h0;
      end else begin
         if (!aw_got && !s_axi_bvalid)
            s_axi_awready <= ~(s_axi_awvalid & s_axi_awready);
         if (!w_got && !s_axi_bvalid)
            s_axi_wready <= ~(s_axi_wvalid & s_axi_wready);
         if (s_axi_awvalid && s_axi_awready) begin
            aw_got  <= 1'b1;
            aw_addr <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_got  <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
         end
         if (wr_go) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= (aw_addr <= OFS_STATUS && aw_addr[1:0] == 2'h0
                             && aw_addr != OFS_COUNTER
                             && aw_addr != OFS_STATUS)
                            ? RESP_OKAY : RESP_SLVERR;
            aw_got       <= 1'b0;
            w_got        <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid  <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready  <= 1'b1;
         end
      end
   end

   // Control registers
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ctrl <= CTRL_RST;
      end else if (wr_go && w_strb[0]) begin
         case (aw_addr)
            OFS_MODE:
               ctrl.run_mode <= run_mode_e'(w_data[POS_RUN +: 2]);
            OFS_CAP_CTRL: begin
               ctrl.capa_en  <= w_data[POS_CAPA_EN];
               ctrl.capa_src <= w_data[POS_CAPA_SRC];
               ctrl.capb_en  <= w_data[POS_CAPB_EN];
            end
            OFS_OUT_CTRL: begin
               ctrl.out_en <= w_data[POS_OUT_EN];
               ctrl.os_en  <= w_data[POS_OS_EN];
            end
            OFS_PRESCALE: begin
               ctrl.clk_sel <= clk_sel_e'(w_data[POS_CLK_SEL +: 2]);
               ctrl.es_trig <= edge_sel_e'(w_data[POS_ES_TRIG +: 2]);
               ctrl.es_cap2 <= edge_sel_e'(w_data[POS_ES_CAP2 +: 2]);
            end
            default: ;
         endcase
      end
   end

   // Count clock: prescaler enable or trigger pin edge
   always_ff @(posedge aclk) begin
      if (!aresetn)
         div <= 4'h0;
      else
         div <= div + 4'h1;
   end

   always_comb begin
      case (ctrl.clk_sel)
         CLK_MAIN:  pre_tick = 1'b1;
         CLK_DIV_A: pre_tick = (div & DIV_MASK_A) == DIV_MASK_A;
         CLK_DIV_B: pre_tick = (div & DIV_MASK_B) == DIV_MASK_B;
         default:   pre_tick = 1'b1;
      endcase
   end

   assign running  = ctrl.run_mode != RUN_STOP;
   assign start_ev = wr_go && w_strb[0] && aw_addr == OFS_MODE
                     && !running && w_data[POS_RUN +: 2] != 2'h0;
   assign pin      = {second_capture_input, trigger_input};
   // Trigger pin sampled at full rate when it is the count clock
   assign samp_en[0] = running & (ctrl.clk_sel == CLK_TRIG_EDGE
                                  | pre_tick);
   assign samp_en[1] = running & pre_tick;

   always_ff @(posedge aclk) begin
      if (!aresetn)
         first_run <= 1'b1;
      else if (start_ev)
         first_run <= 1'b0;
   end

   genvar gi;
   generate
      for (gi = 0; gi < 2; gi = gi + 1) begin : g_filt
         always_ff @(posedge aclk) begin
            if (!aresetn) begin
               sh0[gi]  <= 1'b0;
               sh1[gi]  <= 1'b0;
               filt[gi] <= 1'b0;
            end else if (start_ev) begin
               // After reset a high pin reads as a rise; not on restart
               sh0[gi]  <= first_run ? 1'b0 : pin[gi];
               sh1[gi]  <= first_run ? 1'b0 : pin[gi];
               filt[gi] <= first_run ? 1'b0 : pin[gi];
            end else if (samp_en[gi]) begin
               sh0[gi] <= pin[gi];
               sh1[gi] <= sh0[gi];
               if (sh0[gi] == sh1[gi])
                  filt[gi] <= sh0[gi];
            end
         end
         assign rise[gi] = samp_en[gi] & sh0[gi] & sh1[gi] & ~filt[gi];
         assign fall[gi] = samp_en[gi] & ~sh0[gi] & ~sh1[gi] & filt[gi];
      end
   endgenerate

   assign trig_valid = sel_edge(ctrl.es_trig, rise[0], fall[0]);
   assign cap2_valid = sel_edge(ctrl.es_cap2, rise[1], fall[1]);
   assign tick = running & (ctrl.clk_sel == CLK_TRIG_EDGE ? trig_valid
                                                         : pre_tick);

   // One-shot triggering
   assign os_mode_ok = ctrl.os_en & (ctrl.run_mode == RUN_FREE
                                     | ctrl.run_mode == RUN_EDGE_CLR);
   assign soft_go = os_mode_ok & wr_go & w_strb[0]
                    & aw_addr == OFS_OUT_CTRL
                    & w_data[POS_SOFT_TRIG];
   assign ext_go  = os_mode_ok & trig_valid & ~busy
                    & ctrl.clk_sel != CLK_TRIG_EDGE;
   assign os_go   = soft_go | ext_go;
   assign clear_ev = os_go | (ctrl.run_mode == RUN_EDGE_CLR & trig_valid
                              & ~(ctrl.os_en & busy));

   assign lo_val = capture_compare_b < capture_compare_a
                   ? capture_compare_b : capture_compare_a;
   assign hi_val = capture_compare_b < capture_compare_a
                   ? capture_compare_a : capture_compare_b;
   assign start_hit = busy & ~pulse_q & tick & ~clear_ev
                      & up_counter == lo_val;
   assign end_hit   = busy & pulse_q & tick & ~clear_ev
                      & up_counter == hi_val;

   // Counter keeps running after the pulse until stopped
   always_ff @(posedge aclk) begin
      if (!aresetn)
         up_counter <= 16'h0000;
      else if (!running || clear_ev)
         up_counter <= 16'h0000;
      else if (tick) begin
         if (ctrl.run_mode == RUN_MATCH_CLR
             && up_counter == capture_compare_a)
            up_counter <= 16'h0000;
         else
            up_counter <= up_counter + 16'h0001;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         busy    <= 1'b0;
         pulse_q <= 1'b0;
      end else if (!running) begin
         busy    <= 1'b0;
         pulse_q <= 1'b0;
      end else if (os_go) begin
         busy    <= 1'b1;
         pulse_q <= 1'b0;
      end else if (end_hit) begin
         busy    <= 1'b0;
         pulse_q <= 1'b0;
      end else if (start_hit) begin
         pulse_q <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn)
         pulse_output <= 1'b0;
      else
         pulse_output <= ctrl.out_en & pulse_q;
   end

   // Overflow flag: hardware set wins over software clear
   assign wrap_ev = tick & ~clear_ev & up_counter == CNT_MAX
                    & (ctrl.run_mode != RUN_MATCH_CLR
                       | capture_compare_a == CNT_MAX);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         overflow_flag <= 1'b0;
         ovf_hold      <= 1'b0;
      end else begin
         if (wrap_ev)
            ovf_hold <= 1'b1;
         else if (!running || up_counter == CNT_ONE || clear_ev)
            ovf_hold <= 1'b0;
         if (wrap_ev || ovf_hold)
            overflow_flag <= 1'b1;
         else if (wr_go && w_strb[0] && aw_addr == OFS_MODE)
            overflow_flag <= w_data[POS_OVF];
      end
   end

   // Captures happen on a count tick; content after stop is kept as is
   assign cap_a_ev = ctrl.capa_en & tick & (ctrl.capa_src ? cap2_valid
                     : trig_valid & ctrl.clk_sel != CLK_TRIG_EDGE);
   assign cap_b_ev = ctrl.capb_en & tick & trig_valid
                     & ctrl.clk_sel != CLK_TRIG_EDGE;
   assign match_a_ev = tick & ~ctrl.capa_en & up_counter == capture_compare_a;
   assign match_b_ev = tick & ~ctrl.capb_en & up_counter == capture_compare_b;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         capture_compare_a <= 16'h0000;
         capture_compare_b <= 16'h0000;
      end else begin
         if (cap_a_ev)
            capture_compare_a <= up_counter;
         else if (wr_go && aw_addr == OFS_CC_A)
            capture_compare_a <= merge16(capture_compare_a, w_data, w_strb);
         if (cap_b_ev)
            capture_compare_b <= up_counter;
         else if (wr_go && aw_addr == OFS_CC_B)
            capture_compare_b <= merge16(capture_compare_b, w_data, w_strb);
      end
   end

   // Requests rise one aclk cycle after the capture or match
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         match_a_irq <= 1'b0;
         match_b_irq <= 1'b0;
      end else begin
         match_a_irq <= match_a_ev | cap_a_ev;
         match_b_irq <= match_b_ev | cap_b_ev;
      end
   end

   // Read path has no side effects on the counter or captures
   always_comb begin
      rd_val = 32'h0000_0000;
      rd_ok  = 1'b1;
      case (s_axi_araddr)
         OFS_MODE: begin
            rd_val[POS_RUN +: 2] = ctrl.run_mode;
            rd_val[POS_OVF]      = overflow_flag;
         end
         OFS_CAP_CTRL: begin
            rd_val[POS_CAPA_EN]  = ctrl.capa_en;
            rd_val[POS_CAPA_SRC] = ctrl.capa_src;
            rd_val[POS_CAPB_EN]  = ctrl.capb_en;
         end
         OFS_OUT_CTRL: begin
            rd_val[POS_OUT_EN] = ctrl.out_en;
            rd_val[POS_OS_EN]  = ctrl.os_en;
         end
         OFS_PRESCALE: begin
            rd_val[POS_CLK_SEL +: 2] = ctrl.clk_sel;
            rd_val[POS_ES_TRIG +: 2] = ctrl.es_trig;
            rd_val[POS_ES_CAP2 +: 2] = ctrl.es_cap2;
         end
         OFS_COUNTER: rd_val[15:0] = up_counter;
         OFS_CC_A:    rd_val[15:0] = capture_compare_a;
         OFS_CC_B:    rd_val[15:0] = capture_compare_b;
         OFS_STATUS:  rd_val[1:0]  = {pulse_q, busy};
         default:     rd_ok = 1'b0;
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h0000_0000;
         s_axi_rresp   <= RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rdata   <= rd_val;
         s_axi_rresp   <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
         s_axi_arready <= 1'b1;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   property p_ovf_wrap;
      @(posedge aclk) disable iff (!aresetn)
      wrap_ev |=> overflow_flag && up_counter == 16'h0000;
   endproperty
   a_ovf_wrap: assert property (p_ovf_wrap)
      else $error("overflow flag not set on wrap");

   property p_ovf_hold;
      @(posedge aclk) disable iff (!aresetn)
      wrap_ev |=> overflow_flag [*2];
   endproperty
   a_ovf_hold: assert property (p_ovf_hold)
      else $error("overflow flag cleared before count one");

   property p_soft_start;
      @(posedge aclk) disable iff (!aresetn)
      soft_go && running |=> busy && up_counter == 16'h0000 && !pulse_q;
   endproperty
   a_soft_start: assert property (p_soft_start)
      else $error("software trigger did not restart counter");

   property p_ignore_busy;
      @(posedge aclk) disable iff (!aresetn)
      busy && ctrl.os_en && trig_valid && !end_hit && running
      |=> busy && up_counter != 16'h0000 || $past(up_counter) == CNT_MAX;
   endproperty
   a_ignore_busy: assert property (p_ignore_busy)
      else $error("edge during pulse restarted the counter");

   property p_pulse_idle;
      @(posedge aclk) disable iff (!aresetn)
      !busy |=> !pulse_output;
   endproperty
   a_pulse_idle: assert property (p_pulse_idle)
      else $error("pulse output active outside one-shot");

   property p_irq_next;
      @(posedge aclk) disable iff (!aresetn)
      cap_a_ev |=> match_a_irq && capture_compare_a == $past(up_counter);
   endproperty
   a_irq_next: assert property (p_irq_next)
      else $error("capture or request timing wrong");

   property p_stop_ignore;
      @(posedge aclk) disable iff (!aresetn)
      !running |-> !trig_valid && !cap2_valid && !tick;
   endproperty
   a_stop_ignore: assert property (p_stop_ignore)
      else $error("input acknowledged while stopped");

   property p_pulse_order;
      @(posedge aclk) disable iff (!aresetn)
      start_hit && running |=> pulse_q ##1 pulse_output == ctrl.out_en;
   endproperty
   a_pulse_order: assert property (p_pulse_order)
      else $error("pulse did not start at lower match");

   property p_match_clr_no_os;
      @(posedge aclk) disable iff (!aresetn)
      ctrl.run_mode == RUN_MATCH_CLR |-> !os_go;
   endproperty
   a_match_clr_no_os: assert property (p_match_clr_no_os)
      else $error("one-shot started in match clear mode");
endmodule

// *** sim/pin_source.sv ***
`timescale 1ns/1ps
module pin_source (
   input  wire logic aclk,
   output logic      trig,
   output logic      cap2
);
   initial begin
      trig = 1'b0;
      cap2 = 1'b0;
   end

   // Both pins follow one level, changed just after an edge
   task automatic drive(input logic v, input int hold);
      trig <= v;
      cap2 <= v;
      repeat (hold) @(posedge aclk);
   endtask
endmodule

// *** sim/timer16_one_shot_capture_tb.sv ***
`timescale 1ns/1ps
module timer16_one_shot_capture_tb;
   import tmr16_pkg::*;
   logic        aclk = 1'b0;
   logic        aresetn = 1'b0;
   logic [7:0]  s_axi_awaddr = 8'h00;
   logic [7:0]  s_axi_araddr = 8'h00;
   logic [31:0] s_axi_wdata = 32'h0;
   logic [3:0]  s_axi_wstrb = 4'hF;
   logic        s_axi_awvalid = 1'b0;
   logic        s_axi_wvalid = 1'b0;
   logic        s_axi_bready = 1'b0;
   logic        s_axi_arvalid = 1'b0;
   logic        s_axi_rready = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid;
   logic        s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic        trigger_input, second_capture_input;
   logic        pulse_output, match_a_irq, match_b_irq;
   logic [1:0]  wq[$];
   logic [33:0] rq[$];
   int          pq[$];
   logic [7:0]  iq[$];
   int          mismatches = 0;
   int          cmp_count = 0;
   int          pw = 0;
   int          n, m, p;
   int          na = 0;
   int          nb = 0;
   logic        idle;
   edge_sel_e   es[3] = '{EDGE_FALL, EDGE_RISE, EDGE_BOTH};

   always #12.5 aclk = ~aclk;

   timer16_one_shot_capture u_dut (
      .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
      .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
      .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
      .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
      .s_axi_rvalid, .s_axi_rready, .trigger_input, .second_capture_input,
      .pulse_output, .match_a_irq, .match_b_irq
   );

   pin_source u_src (
      .aclk (aclk),
      .trig (trigger_input),
      .cap2 (second_capture_input)
   );

   task automatic cmp_bus(input logic [33:0] e, input logic [33:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t bus exp %h got %h", $time, e, g);
      end
   endtask

   task automatic cmp_pw(input int e, input int g);
      cmp_count++;
      if (g != e) begin
         mismatches++;
         $display("[FAIL] %0t pulse width exp %0d got %0d", $time, e, g);
      end
   endtask

   task automatic cmp_irq(input logic [7:0] e, input logic [7:0] g);
      cmp_count++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %0t match requests exp %h got %h", $time, e, g);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
      logic aw;
      logic w;
      aw = 1'b1;
      w = 1'b1;
      wq.push_back(r);
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      while (aw || w) begin
         @(posedge aclk);
         if (aw && s_axi_awready) begin
            aw = 1'b0;
            s_axi_awvalid <= 1'b0;
         end
         if (w && s_axi_wready) begin
            w = 1'b0;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      s_axi_bready <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, input logic [33:0] e);
      rq.push_back(e);
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      s_axi_rready <= 1'b0;
   endtask

   // Checker side: oldest note against each result as it appears
   always @(posedge aclk) begin
      if (match_a_irq === 1'b1)
         na++;
      if (match_b_irq === 1'b1)
         nb++;
      if (s_axi_bvalid && s_axi_bready && wq.size() > 0)
         cmp_bus({wq.pop_front(), 32'h0}, {s_axi_bresp, 32'h0});
      if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
         cmp_bus(rq.pop_front(), {s_axi_rresp, s_axi_rdata});
      if (pulse_output === 1'b1)
         pw++;
      else if (pw > 0) begin
         cmp_pw(pq.size() > 0 ? pq.pop_front() : 0, pw);
         cmp_irq(iq.size() > 0 ? iq.pop_front() : 8'h00,
                 {4'(na), 4'(nb)});
         pw = 0;
         na = 0;
         nb = 0;
      end
   end

   task automatic final_report;
      if (pq.size() != 0)
         mismatches++;
      if (mismatches == 0 && cmp_count > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask

   initial begin
      repeat (90000) @(posedge aclk);
      mismatches++;
      final_report;
   end

   initial begin
      void'($urandom(32'hFD4C5FCD));
      repeat (8) @(posedge aclk);
      aresetn <= 1'b1;
      rd(OFS_MODE, 34'h0);
      rd(OFS_OUT_CTRL, 34'h0);
      rd(8'h20, {RESP_SLVERR, 32'h0});
      wr(OFS_COUNTER, 32'h0, RESP_SLVERR);
      // Software start, compare b below then above compare a
      for (int k = 0; k < 2; k++) begin
         n = 4 + $urandom % 16;
         m = n + 10 + $urandom % 16;
         wr(OFS_MODE, 32'h0, RESP_OKAY);
         wr(k ? OFS_CC_A : OFS_CC_B, 32'(n), RESP_OKAY);
         wr(k ? OFS_CC_B : OFS_CC_A, 32'(m), RESP_OKAY);
         wr(OFS_OUT_CTRL, 32'h11, RESP_OKAY);
         wr(OFS_MODE, 32'h8, RESP_OKAY);
         pq.push_back(m - n);
         iq.push_back(8'h11);
         wr(OFS_OUT_CTRL, 32'h51, RESP_OKAY);
         rd(OFS_OUT_CTRL, {RESP_OKAY, 32'h11});
         repeat (m + 8) @(posedge aclk);
      end
      // External trigger for falling, rising and both edges (not EDGE_NONE), return edge while busy
      for (int e = 0; e < 3; e++) begin
         idle = (es[e] == EDGE_FALL);
         wr(OFS_MODE, 32'h0, RESP_OKAY);
         u_src.drive(idle, 2);
         wr(OFS_PRESCALE, 32'({es[e], 4'h0}), RESP_OKAY);
         wr(OFS_MODE, 32'h4, RESP_OKAY);
         pq.push_back(m - n);
         iq.push_back(8'h11);
         u_src.drive(!idle, 4);
         u_src.drive(idle, m + 8);
      end
      u_src.drive(1'b1, 1);
      u_src.drive(1'b0, m + 8);
      wr(OFS_MODE, 32'h0, RESP_OKAY);
      u_src.drive(1'b1, 4);
      u_src.drive(1'b0, m + 8);
      wr(OFS_OUT_CTRL, 32'h0, RESP_OKAY);
      // Two rising edges p apart: both registers capture p - 1
      p = 12 + $urandom % 16;
      wr(OFS_CAP_CTRL, 32'h7, RESP_OKAY);
      wr(OFS_PRESCALE, 32'h50, RESP_OKAY);
      wr(OFS_MODE, 32'h4, RESP_OKAY);
      u_src.drive(1'b1, 4);
      u_src.drive(1'b0, p - 4);
      u_src.drive(1'b1, 4);
      u_src.drive(1'b0, 4);
      rd(OFS_CC_B, {RESP_OKAY, 32'(p - 1)});
      rd(OFS_CC_A, {RESP_OKAY, 32'(p - 1)});
      wr(OFS_MODE, 32'h0, RESP_OKAY);
      wr(OFS_CAP_CTRL, 32'h0, RESP_OKAY);
      wr(OFS_CC_A, 32'hFFFF, RESP_OKAY);
      wr(OFS_MODE, 32'h8, RESP_OKAY);
      repeat (65600) @(posedge aclk);
      rd(OFS_MODE, {RESP_OKAY, 32'h9});
      wr(OFS_MODE, 32'h8, RESP_OKAY);
      rd(OFS_MODE, {RESP_OKAY, 32'h8});
      final_report;
   end
endmodule
